// *** core/wdg_supervision_timer.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Counter advances once per cycle of the separate 128 kHz oscillator.
// - At the selected time-out the configured response is produced.
// - The restart instruction clears the counter; software issues it before time-out.
// - Interrupt mode raises an interrupt, never a reset; it can wake from sleep.
// - Reset mode raises a system reset with no interrupt first.
// - Combined mode interrupts first, then switches to reset mode.
// - The always-on setting forces reset enable high and interrupt enable low.
// - Counting continues in every sleep mode once enabled.
// - Clearing reset enable or changing time-out needs a timed sequence.
module wdg_supervision_timer
  import wdg_pkg::*;
#(
  parameter int CNT_W = 20,
  parameter int TO_BASE = 2048
) (
  // Clock, reset and clock enable.
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Oscillator, strap and processor restart instruction.
  input wire logic osc_i,
  input wire logic always_on_setting_i,
  input wire logic counter_restart_instr_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Responses.
  output logic irq_o,
  output logic sys_reset_o
);

  typedef struct packed {
    logic rme;
    logic ime;
    logic [WDG_SEL_W-1:0] sel;
    logic chg_en;
    logic [WDG_WIN_W-1:0] win;
    logic [CNT_W-1:0] cnt;
    logic flag;
    logic mask;
    logic irq;
    logic rst;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } wdg_state_s;

  localparam wdg_state_s WDG_STATE_RST = '{
    rme: WDG_RME_RST,
    ime: WDG_IME_RST,
    sel: WDG_SEL_RST,
    mask: WDG_MASK_RST,
    default: '0
  };

  wdg_state_s s_q;
  wdg_state_s s_d;
  logic tick;
  logic [CNT_W-1:0] limit;
  logic running;
  logic expire;
  logic restart;
  logic access;
  logic wr;
  logic mapped;
  logic unlock_wr;

  wdg_osc_tick u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .osc_i(osc_i),
    .tick_o(tick)
  );

  assign access = psel_i & penable_i & s_q.ready;
  assign wr = access & pwrite_i;
  assign mapped = (paddr_i == WDG_CTRL_ADDR) || (paddr_i == WDG_STAT_ADDR) ||
                  (paddr_i == WDG_MASK_ADDR) || (paddr_i == WDG_RESTART_ADDR) ||
                  (paddr_i == WDG_COUNT_ADDR);
  assign limit = CNT_W'(TO_BASE) << s_q.sel;
  assign running = s_q.rme | s_q.ime;
  // Sleep has no input here: the counter only depends on the mode bits.
  assign expire = tick & running & (s_q.cnt >= limit - CNT_W'(1));
  assign restart = counter_restart_instr_i |
                   (wr && paddr_i == WDG_RESTART_ADDR);
  // The window opens only if the change bit and reset enable are written together.
  assign unlock_wr = wr && paddr_i == WDG_CTRL_ADDR &&
                     pwdata_i[WDG_CTRL_CHG_BIT] && pwdata_i[WDG_CTRL_RME_BIT];

  always_comb begin
    s_d = s_q;
    s_d.rst = 1'b0;
    s_d.ready = psel_i & ~penable_i;
    s_d.err = psel_i & ~penable_i & ~mapped;

    // Counter.
    if (restart || expire) begin
      s_d.cnt = '0;
    end else if (tick && running) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end

    // Expiry response.
    if (expire) begin
      if (s_q.ime) begin
        s_d.flag = 1'b1;
        if (s_q.rme) begin
          s_d.ime = 1'b0;
        end
      end else begin
        s_d.rst = 1'b1;
      end
    end

    // Unlock window.
    if (s_q.chg_en) begin
      if (s_q.win == WDG_WIN_W'(WDG_UNLOCK_CYC - 1)) begin
        s_d.chg_en = 1'b0;
      end else begin
        s_d.win = s_q.win + WDG_WIN_W'(1);
      end
    end

    // Register writes.
    if (wr && paddr_i == WDG_CTRL_ADDR) begin
      s_d.ime = pwdata_i[WDG_CTRL_IME_BIT];
      if (s_q.chg_en) begin
        s_d.rme = pwdata_i[WDG_CTRL_RME_BIT];
        s_d.sel = pwdata_i[WDG_CTRL_SEL_LSB +: WDG_SEL_W];
        s_d.chg_en = 1'b0;
      end else begin
        s_d.rme = s_q.rme | pwdata_i[WDG_CTRL_RME_BIT];
        if (unlock_wr) begin
          s_d.chg_en = 1'b1;
          s_d.win = '0;
        end
      end
    end
    if (wr && paddr_i == WDG_MASK_ADDR) begin
      s_d.mask = pwdata_i[WDG_STAT_EXP_BIT];
    end
    // A new expiry wins over a clear in the same cycle.
    if (wr && paddr_i == WDG_STAT_ADDR && pwdata_i[WDG_STAT_EXP_BIT] &&
        !(expire && s_q.ime)) begin
      s_d.flag = 1'b0;
    end

    // The strap overrides every write of reset enable and interrupt enable.
    if (always_on_setting_i) begin
      s_d.rme = 1'b1;
      s_d.ime = 1'b0;
    end

    s_d.irq = s_d.flag & s_d.mask;

    // Read data.
    s_d.rdata = '0;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        WDG_CTRL_ADDR: begin
          s_d.rdata[WDG_CTRL_RME_BIT] = s_q.rme;
          s_d.rdata[WDG_CTRL_IME_BIT] = s_q.ime;
          s_d.rdata[WDG_CTRL_CHG_BIT] = s_q.chg_en;
          s_d.rdata[WDG_CTRL_SEL_LSB +: WDG_SEL_W] = s_q.sel;
        end
        WDG_STAT_ADDR: begin
          s_d.rdata[WDG_STAT_EXP_BIT] = s_q.flag;
          s_d.rdata[WDG_STAT_AON_BIT] = always_on_setting_i;
        end
        WDG_MASK_ADDR: begin
          s_d.rdata[WDG_STAT_EXP_BIT] = s_q.mask;
        end
        WDG_COUNT_ADDR: begin
          s_d.rdata[CNT_W-1:0] = s_q.cnt;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= WDG_STATE_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.rdata;
  assign pready_o = s_q.ready;
  assign pslverr_o = s_q.err;
  assign irq_o = s_q.irq;
  assign sys_reset_o = s_q.rst;

  default clocking wdg_cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  AST_RESET_ONLY: assert property (
    ce_i && expire && !s_q.ime |=> sys_reset_o && $stable(s_q.flag))
    else $error("reset-only expiry did not reset cleanly");

  AST_INT_ONLY: assert property (
    ce_i && expire && s_q.ime && !s_q.rme |=> s_q.flag && !sys_reset_o)
    else $error("interrupt-only expiry misbehaved");

  AST_COMBINED: assert property (
    ce_i && expire && s_q.ime && s_q.rme && !always_on_setting_i
    |=> s_q.flag && !s_q.ime && s_q.rme && !sys_reset_o)
    else $error("combined expiry did not switch to reset mode");

  AST_ALWAYS_ON: assert property (
    !$past(rst_i) && $past(ce_i) && $past(always_on_setting_i) |-> s_q.rme && !s_q.ime)
    else $error("always-on setting did not force reset mode");

  AST_RESTART: assert property (
    ce_i && counter_restart_instr_i |=> s_q.cnt == '0)
    else $error("restart did not clear the counter");

  AST_COUNT: assert property (
    ce_i && tick && running && !expire && !restart |=> s_q.cnt == $past(s_q.cnt) + 1'b1)
    else $error("counter did not advance on an oscillator tick");

  AST_LOCKED: assert property (
    ce_i && !s_q.chg_en && !always_on_setting_i && s_q.rme |=> s_q.rme && $stable(s_q.sel))
    else $error("protected setting changed without unlock");

  AST_WINDOW: assert property (
    ce_i && $rose(s_q.chg_en) |-> ##[1:4] !s_q.chg_en)
    else $error("unlock window did not close");

  AST_IRQ: assert property (
    irq_o == (s_q.flag && s_q.mask))
    else $error("interrupt output does not follow flag and mask");

  // Bus handshake: every transfer gets exactly one wait-free access cycle.
  AST_READY_NEXT: assert property (
    ce_i && psel_i && !penable_i |=> pready_o)
    else $error("access phase did not complete at once");

  AST_READY_PULSE: assert property (
    ce_i && pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");

  AST_ERR_ONLY_READY: assert property (
    pslverr_o |-> pready_o)
    else $error("error response without ready");

  AST_UNMAPPED: assert property (
    ce_i && psel_i && !penable_i && !mapped |=> pslverr_o && prdata_o == '0)
    else $error("unmapped address not refused");

  AST_MAPPED: assert property (
    ce_i && psel_i && !penable_i && mapped |=> !pslverr_o)
    else $error("mapped address refused");

  AST_RDATA_IDLE: assert property (
    ce_i && !(psel_i && !penable_i && !pwrite_i) |=> prdata_o == '0)
    else $error("read data left on the bus outside a read");

  // Counter and response checks.
  AST_RESET_CAUSE: assert property (
    ce_i && !expire |=> !sys_reset_o)
    else $error("system reset without expiry");

  AST_IDLE_HOLD: assert property (
    ce_i && !running && !restart |=> $stable(s_q.cnt))
    else $error("counter moved while disabled");

  AST_RESTART_REG: assert property (
    ce_i && wr && paddr_i == WDG_RESTART_ADDR |=> s_q.cnt == '0)
    else $error("restart register write did not clear the counter");

  AST_FREEZE: assert property (
    !ce_i |=> $stable(s_q))
    else $error("state changed while the clock enable was low");

  AST_W1C: assert property (
    ce_i && wr && paddr_i == WDG_STAT_ADDR && pwdata_i[WDG_STAT_EXP_BIT] && !expire
    |=> !s_q.flag)
    else $error("expiry flag not cleared by a one");

  // Configuration protection checks.
  AST_WIN_OPEN: assert property (
    ce_i && unlock_wr && !s_q.chg_en |=> s_q.chg_en)
    else $error("unlock write did not open the window");

  AST_PROTECTED: assert property (
    ce_i && wr && paddr_i == WDG_CTRL_ADDR && s_q.chg_en
    |=> s_q.sel == $past(pwdata_i[WDG_CTRL_SEL_LSB +: WDG_SEL_W]) && !s_q.chg_en)
    else $error("protected write inside the window not taken");

endmodule

// *** core/wdg_pkg.sv ***
package wdg_pkg;

  // Register byte addresses.
  localparam logic [7:0] WDG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] WDG_STAT_ADDR = 8'h04;
  localparam logic [7:0] WDG_MASK_ADDR = 8'h08;
  localparam logic [7:0] WDG_RESTART_ADDR = 8'h0c;
  localparam logic [7:0] WDG_COUNT_ADDR = 8'h10;

  // Control register fields.
  localparam int WDG_CTRL_RME_BIT = 0;
  localparam int WDG_CTRL_IME_BIT = 1;
  localparam int WDG_CTRL_CHG_BIT = 2;
  localparam int WDG_CTRL_SEL_LSB = 4;
  localparam int WDG_SEL_W = 3;

  // Status register fields.
  localparam int WDG_STAT_EXP_BIT = 0;
  localparam int WDG_STAT_AON_BIT = 1;

  // Oscillator and system timing.
  localparam int WDG_OSC_KHZ = 128;
  localparam int WDG_MCLK_KHZ = 125000;
  // Cycles of the system clock during which a protected change is accepted.
  localparam int WDG_UNLOCK_CYC = 4;
  localparam int WDG_WIN_W = 3;

  // Reset values.
  localparam logic [WDG_SEL_W-1:0] WDG_SEL_RST = 3'h0;
  localparam logic WDG_RME_RST = 1'b0;
  localparam logic WDG_IME_RST = 1'b0;
  localparam logic WDG_MASK_RST = 1'b0;

endpackage

// *** core/wdg_osc_tick.sv ***
`timescale 1ns/1ps
// Brings the oscillator into the system clock and marks each of its rising edges.
module wdg_osc_tick
  import wdg_pkg::*;
(
  // Clock and control.
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Oscillator in, one-cycle tick out.
  input wire logic osc_i,
  output logic tick_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic tick;
  } wdg_tick_s;

  wdg_tick_s s_q;
  wdg_tick_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = osc_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.tick = s_q.sync & ~s_q.prev;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule

// *** tb/wdg_core_model.sv ***
`timescale 1ns/1ps
// Stands in for the core and the free-running oscillator beside the timer.
module wdg_core_model (
  // Clock and restart request from the bench.
  input wire logic mclk_i,
  input wire logic kick_i,
  // Oscillator and restart pulse to the timer.
  output logic osc_o,
  output logic restart_o
);
  initial begin
    osc_o = 1'b0;
    forever #3906.25 osc_o = ~osc_o;
  end
  always @(posedge mclk_i) begin
    restart_o <= kick_i;
  end
endmodule

// *** tb/test_wdg_supervision_timer.sv ***
`timescale 1ns/1ps
module test_wdg_supervision_timer
  import wdg_pkg::*;
();
  localparam int OSC = WDG_MCLK_KHZ / WDG_OSC_KHZ;
  localparam int TOB = 4;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} wdg_row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic aon = 1'b0;
  logic kick = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic osc, rstr, pready, pslverr, irq, sreset, er;
  logic [31:0] prdata, rd;
  logic [1:0] ev;
  int mismatches = 0;
  int comparisons = 0;
  wdg_row_s rows[5] = '{'{WDG_CTRL_ADDR, 32'h0, 1'b0}, '{WDG_STAT_ADDR, 32'h0, 1'b0},
    '{WDG_MASK_ADDR, 32'h0, 1'b0}, '{WDG_COUNT_ADDR, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b1}};

  wdg_core_model i_wdg_core_model (.mclk_i(mclk), .kick_i(kick), .osc_o(osc), .restart_o(rstr));
  wdg_supervision_timer #(.TO_BASE(TOB)) i_wdg_supervision_timer (
    .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .osc_i(osc), .always_on_setting_i(aon),
    .counter_restart_instr_i(rstr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .sys_reset_o(sreset));

  initial begin
    forever #4 mclk = ~mclk;
  end

  initial begin
    #640000;
    mismatches++;
    finish_test();
  end

  task finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  // Collects irq and system reset seen until a selected one appears.
  task run(input int lim, input logic [1:0] stop);
    ev = 2'b00;
    for (int i = 0; i < lim && (ev & stop) == 2'b00; i++) begin
      @(posedge mclk);
      ev = ev | {irq, sreset};
    end
  endtask

  task bump();
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      rdc(rows[i].a, rows[i].d);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    apb(1'b1, WDG_CTRL_ADDR, 32'h1);
    run((TOB - 1) * OSC - 100, 2'b11);
    chk({30'h0, ev}, 32'h0);
    run(2 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        apb(1'b1, WDG_RESTART_ADDR, 32'h1);
      end else begin
        bump();
      end
      run(2 * OSC, 2'b11);
      chk({30'h0, ev}, 32'h0);
    end
    apb(1'b1, WDG_CTRL_ADDR, 32'h0);
    rdc(WDG_CTRL_ADDR, 32'h1);
    apb(1'b1, WDG_CTRL_ADDR, 32'h5);
    repeat (WDG_UNLOCK_CYC + 2) @(posedge mclk);
    apb(1'b1, WDG_CTRL_ADDR, 32'h0);
    rdc(WDG_CTRL_ADDR, 32'h1);
    apb(1'b1, WDG_CTRL_ADDR, 32'h5);
    apb(1'b1, WDG_CTRL_ADDR, 32'h2);
    rdc(WDG_CTRL_ADDR, 32'h2);
    apb(1'b1, WDG_MASK_ADDR, 32'h1);
    run(5 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h2);
    run(9 * OSC, 2'b01);
    chk({30'h0, ev}, 32'h2);
    rdc(WDG_STAT_ADDR, 32'h1);
    apb(1'b1, WDG_MASK_ADDR, 32'h0);
    run(2, 2'b00);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, WDG_MASK_ADDR, 32'h1);
    apb(1'b1, WDG_STAT_ADDR, 32'h1);
    run(2, 2'b00);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, WDG_CTRL_ADDR, 32'h3);
    bump();
    run(5 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h2);
    rdc(WDG_CTRL_ADDR, 32'h1);
    apb(1'b1, WDG_STAT_ADDR, 32'h1);
    run(2, 2'b00);
    run(5 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h1);
    aon <= 1'b1;
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rdc(WDG_CTRL_ADDR, 32'h1);
    rdc(WDG_STAT_ADDR, 32'h2);
    apb(1'b1, WDG_CTRL_ADDR, 32'h2);
    rdc(WDG_CTRL_ADDR, 32'h1);
    ce <= 1'b0;
    run(5 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h0);
    ce <= 1'b1;
    apb(1'b1, WDG_CTRL_ADDR, 32'h5);
    apb(1'b1, WDG_CTRL_ADDR, 32'h10);
    rdc(WDG_CTRL_ADDR, 32'h11);
    bump();
    run(5 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h0);
    run(5 * OSC, 2'b11);
    chk({30'h0, ev}, 32'h1);
    finish_test();
  end
endmodule
